// ### inc/vram_host_pkg.sv
/*
	constants, command and pin types for the video dram random port controller.
	assumes one 200 MHz clock and a multiport video dram wired to the pin struct.
*/
package vram_host_pkg;
	localparam int CLK_MHZ = 200;
	localparam int T_STEP_NS = 15;
	localparam int T_ACCESS_NS = 60;
	localparam int T_PRE_NS = 80;
	localparam int T_RAS_MAX_NS = 10000;
	localparam int REFRESH_MS = 8;
	localparam int ROW_COUNT = 512;
	localparam int TMR_W = 12;
	localparam int REF_W = 16;
	// least times round up, the refresh spacing rounds down
	localparam int STEP_CYC = (T_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int PRE_CYC = (T_PRE_NS * CLK_MHZ + 999) / 1000;
	localparam int RAS_MAX_CYC = (T_RAS_MAX_NS * CLK_MHZ) / 1000;
	localparam int REFRESH_CYC = (REFRESH_MS * 1000000 / ROW_COUNT) * CLK_MHZ / 1000;
	localparam logic [TMR_W-1:0] STEP_LD = TMR_W'(STEP_CYC - 1);
	localparam logic [TMR_W-1:0] ACCESS_LD = TMR_W'(ACCESS_CYC - 1);
	localparam logic [TMR_W-1:0] PRE_LD = TMR_W'(PRE_CYC - 1);
	localparam logic [TMR_W-1:0] RAS_MAX_LD = TMR_W'(RAS_MAX_CYC - 1);
	localparam logic [REF_W-1:0] REFRESH_LD = REF_W'(REFRESH_CYC - 1);

	typedef enum logic [3:0] {
		OP_READ, OP_WRITE, OP_WR_MASK, OP_WR_PERSIST,
		OP_BLOCK, OP_BLOCK_MASK, OP_BLOCK_PERSIST, OP_LOAD_MASK,
		OP_LOAD_COLOR, OP_REF_RAS, OP_REF_CBR, OP_XFER_WR,
		OP_XFER_ALT, OP_XFER_PSEUDO, OP_XFER_RD, OP_XFER_SPLIT
	} op_t;

	typedef struct packed {
		op_t op;
		logic [8:0] row;
		logic [8:0] col;
		logic [3:0] wmask;
		logic [3:0] data;
		logic keep_open;
	} cmd_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic w_n;
		logic xfer_output_enable_n;
		logic special_function_sel;
		logic serial_enable_n;
		logic [8:0] addr;
		logic [3:0] random_data_lines;
		logic dq_oe;
	} pins_t;

	localparam pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, w_n: 1'b1,
		xfer_output_enable_n: 1'b1, special_function_sel: 1'b0,
		serial_enable_n: 1'b1, addr: 9'h000, random_data_lines: 4'h0, dq_oe: 1'b0};
endpackage

// ### hw/vram_host.sv
/*
	host side controller for the random port of a multiport video dram.
	assumes the dram pins are wired to PINS_OUT and DQ_IN; the dq wire is resolved outside.
*/
`timescale 1ns/100ps
// Contract
// - we low, sel low at row fall: reload mask
// - mask at row fall, data at later strobe
// - full page of accesses in one row; here page mode ends once the row has been low about 10 us (RAS_MAX_CYC cycles)
// - every row refreshed each eight ms
// - row-only refresh keeps column strobe high
// - sel high both falls loads color
// - we high during refresh cycles
module vram_host
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// command port
	input wire logic CMD_VALID_IN,
	input wire vram_host_pkg::cmd_t CMD_IN,
	output logic CMD_READY_OUT,
	// read answer
	output logic RSP_VALID_OUT,
	output logic [3:0] RSP_DATA_OUT,
	// dram pins
	output vram_host_pkg::pins_t PINS_OUT,
	input wire logic [3:0] DQ_IN
);
	import vram_host_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ROW, ST_COL, ST_CAS, ST_CASUP, ST_PAGE,
		ST_PRE} state_t;

	// levels of xfer oe, we, sel, serial enable at the row strobe fall
	function automatic logic [3:0] ras_ctl(input op_t op);
		case (op)
			OP_WR_MASK, OP_BLOCK_MASK: ras_ctl = 4'h9;
			OP_WR_PERSIST, OP_BLOCK_PERSIST: ras_ctl = 4'hb;
			OP_LOAD_MASK, OP_LOAD_COLOR: ras_ctl = 4'hf;
			OP_REF_RAS, OP_REF_CBR: ras_ctl = 4'hd;
			OP_XFER_WR: ras_ctl = 4'h0;
			OP_XFER_ALT: ras_ctl = 4'h3;
			OP_XFER_PSEUDO: ras_ctl = 4'h1;
			OP_XFER_RD: ras_ctl = 4'h5;
			OP_XFER_SPLIT: ras_ctl = 4'h7;
			default: ras_ctl = 4'hd;
		endcase
	endfunction

	function automatic logic is_wr(input op_t op);
		is_wr = (op >= OP_WRITE) && (op <= OP_LOAD_COLOR);
	endfunction

	function automatic logic is_ref(input op_t op);
		is_ref = (op == OP_REF_RAS) || (op == OP_REF_CBR);
	endfunction

	function automatic logic is_xfer(input op_t op);
		is_xfer = op >= OP_XFER_WR;
	endfunction

	function automatic logic is_block(input op_t op);
		is_block = (op >= OP_BLOCK) && (op <= OP_BLOCK_PERSIST);
	endfunction

	// column phase: address flows before the strobe, write data or enables ahead of it
	function automatic pins_t col_pins(input pins_t p, input cmd_t c);
		pins_t r;
		r = p;
		r.addr = c.col;
		r.special_function_sel = is_block(c.op) || (c.op == OP_LOAD_COLOR);
		r.w_n = !is_wr(c.op);
		r.random_data_lines = c.data;
		r.dq_oe = is_wr(c.op);
		if (!is_xfer(c.op))
			r.xfer_output_enable_n = is_wr(c.op);
		col_pins = r;
	endfunction

	state_t st_q, st_d;
	cmd_t cmd_q, cmd_d;
	pins_t pins_q, pins_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [TMR_W-1:0] ras_age_q;
	logic [REF_W-1:0] ref_tmr_q;
	logic ref_pend_q, ref_clr, ref_tick;
	logic rsp_v_q, rsp_v_d;
	logic [3:0] rdata_q, rdata_d;
	logic [3:0] dq_s1_q, dq_s2_q;

	wire tmr_done = tmr_q == '0;
	wire ras_old = ras_age_q >= RAS_MAX_LD;
	wire page_ok = (CMD_IN.row == cmd_q.row) && !ras_old && !ref_pend_q && !is_ref(CMD_IN.op)
		&& !is_xfer(CMD_IN.op) && (CMD_IN.op != OP_LOAD_MASK) && (CMD_IN.op != OP_WR_MASK)
		&& (CMD_IN.op != OP_BLOCK_MASK) && ((CMD_IN.op == cmd_q.op)
		|| (CMD_IN.op <= OP_WRITE && cmd_q.op <= OP_WRITE));
	wire cmd_rdy = ((st_q == ST_IDLE) && !ref_pend_q) || ((st_q == ST_PAGE) && page_ok);
	wire take = CMD_VALID_IN && cmd_rdy;
	assign ref_tick = ref_tmr_q == REFRESH_LD;
	assign CMD_READY_OUT = cmd_rdy;
	assign RSP_VALID_OUT = rsp_v_q;
	assign RSP_DATA_OUT = rdata_q;
	assign PINS_OUT = pins_q;

	always_comb
	begin
		st_d = st_q;
		cmd_d = cmd_q;
		pins_d = pins_q;
		tmr_d = tmr_done ? tmr_q : tmr_q - 1'b1;
		rsp_v_d = 1'b0;
		rdata_d = rdata_q;
		ref_clr = 1'b0;
		case (st_q)
			ST_IDLE:
			begin
				pins_d = PINS_IDLE;
				tmr_d = STEP_LD;
				if (ref_pend_q)
				begin
					cmd_d = '0;
					cmd_d.op = OP_REF_CBR;
					ref_clr = 1'b1;
					st_d = ST_SETUP;
				end
				else if (take)
				begin
					cmd_d = CMD_IN;
					st_d = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				pins_d.addr = cmd_q.row;
				{pins_d.xfer_output_enable_n, pins_d.w_n, pins_d.special_function_sel,
					pins_d.serial_enable_n} = ras_ctl(cmd_q.op);
				pins_d.random_data_lines = cmd_q.wmask;
				pins_d.dq_oe = (cmd_q.op == OP_WR_MASK) || (cmd_q.op == OP_BLOCK_MASK);
				pins_d.cas_n = cmd_q.op != OP_REF_CBR;
				if (tmr_done)
				begin
					pins_d.ras_n = 1'b0;
					st_d = ST_ROW;
					tmr_d = STEP_LD;
				end
			end
			ST_ROW:
			begin
				pins_d.dq_oe = 1'b0;
				if (tmr_done)
				begin
					if (is_ref(cmd_q.op))
					begin
						st_d = ST_CAS;
						tmr_d = ACCESS_LD;
					end
					else
					begin
						pins_d = col_pins(pins_q, cmd_q);
						st_d = ST_COL;
						tmr_d = STEP_LD;
					end
				end
			end
			ST_COL:
				if (tmr_done)
				begin
					pins_d.cas_n = 1'b0;
					st_d = ST_CAS;
					tmr_d = ACCESS_LD;
				end
			ST_CAS:
				if (tmr_done && is_ref(cmd_q.op))
				begin
					pins_d = PINS_IDLE;
					st_d = ST_PRE;
					tmr_d = PRE_LD;
				end
				else if (tmr_done)
				begin
					rdata_d = dq_s2_q;
					rsp_v_d = cmd_q.op == OP_READ;
					pins_d.cas_n = 1'b1;
					pins_d.w_n = 1'b1;
					pins_d.dq_oe = 1'b0;
					pins_d.special_function_sel = 1'b0;
					pins_d.xfer_output_enable_n = 1'b1;
					st_d = ST_CASUP;
					tmr_d = STEP_LD;
				end
			ST_CASUP:
				if (tmr_done && cmd_q.keep_open && !is_xfer(cmd_q.op))
					st_d = ST_PAGE;
				else if (tmr_done)
				begin
					pins_d = PINS_IDLE;
					st_d = ST_PRE;
					tmr_d = PRE_LD;
				end
			ST_PAGE:
				if (take)
				begin
					cmd_d = CMD_IN;
					pins_d = col_pins(pins_q, CMD_IN);
					st_d = ST_COL;
					tmr_d = STEP_LD;
				end
				else if (CMD_VALID_IN || ref_pend_q || ras_old)
				begin
					pins_d = PINS_IDLE;
					st_d = ST_PRE;
					tmr_d = PRE_LD;
				end
			ST_PRE:
				if (tmr_done)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
		begin
			st_q <= ST_IDLE;
			cmd_q <= '0;
			pins_q <= PINS_IDLE;
			tmr_q <= '0;
			rsp_v_q <= 1'b0;
			rdata_q <= 4'h0;
		end
		else
		begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			pins_q <= pins_d;
			tmr_q <= tmr_d;
			rsp_v_q <= rsp_v_d;
			rdata_q <= rdata_d;
		end

	// refresh pacing, row low age and input synchroniser
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
		begin
			ref_tmr_q <= '0;
			ref_pend_q <= 1'b0;
			ras_age_q <= '0;
			dq_s1_q <= 4'h0;
			dq_s2_q <= 4'h0;
		end
		else
		begin
			ref_tmr_q <= ref_tick ? '0 : ref_tmr_q + 1'b1;
			ref_pend_q <= ref_tick || (ref_pend_q && !ref_clr);
			ras_age_q <= pins_q.ras_n ? '0 : (ras_old ? ras_age_q : ras_age_q + 1'b1);
			dq_s1_q <= DQ_IN;
			dq_s2_q <= dq_s1_q;
		end

	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	chk_mask_reload_pins: assert property ($fell(pins_q.ras_n) && cmd_q.op == OP_WR_MASK
		|-> !pins_q.w_n && !pins_q.special_function_sel && pins_q.dq_oe
		&& pins_q.random_data_lines == cmd_q.wmask) else $error("mask reload levels wrong");
	chk_persist_sel: assert property ($fell(pins_q.ras_n) && cmd_q.op == OP_WR_PERSIST
		|-> !pins_q.w_n && pins_q.special_function_sel) else $error("persistent levels wrong");
	chk_no_dq_clash: assert property (!pins_q.cas_n && !pins_q.xfer_output_enable_n
		|-> !pins_q.dq_oe) else $error("dq driven while dram may drive");
	chk_early_write: assert property ($fell(pins_q.cas_n) && is_wr(cmd_q.op)
		|-> !$past(pins_q.w_n, 1) && pins_q.dq_oe) else $error("write strobe not early");
	chk_xfer_levels: assert property ($fell(pins_q.ras_n) && is_xfer(cmd_q.op)
		|-> !pins_q.xfer_output_enable_n && !pins_q.dq_oe) else $error("transfer levels wrong");
	chk_cbr_order: assert property ($fell(pins_q.ras_n) && !pins_q.cas_n
		|-> cmd_q.op == OP_REF_CBR && pins_q.w_n) else $error("column low at row fall");
	chk_ras_only: assert property (!pins_q.ras_n && cmd_q.op == OP_REF_RAS
		|-> pins_q.cas_n && pins_q.w_n) else $error("column strobe in row-only refresh");
	chk_block_sel: assert property ($fell(pins_q.cas_n) && is_block(cmd_q.op)
		|-> pins_q.special_function_sel && pins_q.dq_oe) else $error("block write sel low");
	chk_read_answer: assert property ($fell(pins_q.cas_n) && cmd_q.op == OP_READ
		|-> ##(ACCESS_CYC) rsp_v_q) else $error("read answer late");
	chk_refresh_pace: assert property ($rose(ref_pend_q)
		|-> ##[1:600] !ref_pend_q) else $error("refresh not started in time");
endmodule

// ### test/vram_dev_model.sv
/*
	behavioural model of the video dram random port, watching the host pins.
	assumes pins change only on host clock edges; host faults are counted.
*/
`timescale 1ns/100ps
module vram_dev_model
(
	// host pins
	input wire vram_host_pkg::pins_t PINS_IN,
	// resolved data wire and fault count
	output wire logic [3:0] DQ_OUT,
	output int FAULTS_OUT
);
	import vram_host_pkg::*;
	logic [3:0] mem [logic [17:0]];
	logic [3:0] mask_q = 4'hf;
	logic [3:0] color_q = 4'h0;
	logic [3:0] q = 4'h0;
	logic [3:0] last = 4'h0;
	logic [3:0] d;
	logic [8:0] row = 9'h000;
	logic cbr = 1'b0;
	logic xfer = 1'b0;
	logic w_r = 1'b1;
	logic sel_r = 1'b0;
	logic rd = 1'b0;
	logic dv;
	pins_t p = PINS_IDLE;
	realtime t_ref = 0.0;
	// released wire shows the inverse of the last driven value
	assign DQ_OUT = PINS_IN.dq_oe ? PINS_IN.random_data_lines :
		(rd && !PINS_IN.cas_n && !PINS_IN.xfer_output_enable_n) ? q : ~last;
	initial FAULTS_OUT = 0;
	task automatic put(input logic [17:0] a, input logic [3:0] v);
		logic [3:0] m;
		m = w_r ? 4'hf : mask_q;
		mem[a] = (v & m) | ((mem.exists(a) ? mem[a] : 4'h0) & ~m);
	endtask
	always @(PINS_IN)
	begin
		d = p.dq_oe ? p.random_data_lines : ~last;
		if (p.ras_n && !PINS_IN.ras_n)
		begin
			cbr = !p.cas_n;
			xfer = !p.xfer_output_enable_n;
			w_r = p.w_n;
			sel_r = p.special_function_sel;
			row = p.addr;
			if (!cbr && !xfer && !w_r && !sel_r)
				mask_q = d;
			if (cbr && !p.w_n)
				FAULTS_OUT++;
			if (cbr && $realtime - t_ref > REFRESH_CYC * 1000.0 / CLK_MHZ + 1000.0)
				FAULTS_OUT++;
			if (cbr)
				t_ref = $realtime;
		end
		if (PINS_IN.ras_n && !p.ras_n)
			rd = 1'b0;
		if (!PINS_IN.ras_n && p.cas_n && !PINS_IN.cas_n && !cbr && !xfer)
		begin
			rd = p.w_n;
			q = mem.exists({row, p.addr}) ? mem[{row, p.addr}] : 4'h0;
			if (!p.w_n && w_r && sel_r && p.special_function_sel)
				color_q = d;
			else if (!p.w_n && w_r && sel_r)
				mask_q = d;
			else if (!p.w_n && p.special_function_sel)
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (d[i])
						put({row, p.addr[8:2], 2'(i)}, color_q);
				end
			end
			else if (!p.w_n)
				put({row, p.addr}, d);
		end
		dv = rd && !PINS_IN.cas_n && !PINS_IN.xfer_output_enable_n;
		if (PINS_IN.dq_oe && dv)
			FAULTS_OUT++;
		if (PINS_IN.dq_oe)
			last = PINS_IN.random_data_lines;
		else if (dv)
			last = q;
		p = PINS_IN;
	end
endmodule

// ### test/vram_host_tb.sv
/*
	self-checking bench for the video dram host controller.
	assumes the dram model resolves the data wire.
*/
`timescale 1ns/100ps
module vram_host_tb;
	import vram_host_pkg::*;
	logic clk;
	logic rst_n;
	logic valid;
	cmd_t cmd;
	logic ready;
	logic rsp_v;
	logic [3:0] rsp_d;
	pins_t pins;
	wire [3:0] dq;
	int faults;
	int bad_count = 0;
	int n_tests = 0;
	logic [31:0] rs = 32'h36b65e13;
	logic [3:0] mem [logic [17:0]];
	logic [3:0] msk = 4'hf;
	logic [3:0] col = 4'h0;
	logic [31:0] expq [$];
	vram_host uut (.CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(valid), .CMD_IN(cmd),
		.CMD_READY_OUT(ready), .RSP_VALID_OUT(rsp_v), .RSP_DATA_OUT(rsp_d),
		.PINS_OUT(pins), .DQ_IN(dq));
	vram_dev_model dev (.PINS_IN(pins), .DQ_OUT(dq), .FAULTS_OUT(faults));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic put(input logic [17:0] a, input logic [3:0] v, input logic [3:0] m);
		mem[a] = (v & m) | ((mem.exists(a) ? mem[a] : 4'h0) & ~m);
	endtask
	// note the expected effect, then offer the command until taken
	task automatic send(input op_t op, input logic [8:0] row, input logic [8:0] c,
		input logic [3:0] wm, input logic [3:0] d, input logic k);
		bit r;
		int n;
		n = 0;
		if (op == OP_WR_MASK || op == OP_BLOCK_MASK)
			msk = wm;
		case (op)
			OP_READ: expq.push_back(mem.exists({row, c}) ? mem[{row, c}] : 4'h0);
			OP_WRITE: put({row, c}, d, 4'hf);
			OP_WR_MASK, OP_WR_PERSIST: put({row, c}, d, msk);
			OP_BLOCK, OP_BLOCK_MASK, OP_BLOCK_PERSIST:
				for (int i = 0; i < 4; i++)
					if (d[i])
						put({row, c[8:2], 2'(i)}, col, op == OP_BLOCK ? 4'hf : msk);
			OP_LOAD_MASK: msk = d;
			OP_LOAD_COLOR: col = d;
			default: ;
		endcase
		cmd = '{op, row, c, wm, d, k};
		valid = 1'b1;
		do
		begin
			#3 r = ready;
			@(posedge clk);
			#1 n++;
		end
		while (!r && n < 4000);
		if (!r)
			check(1, 0);
	endtask
	always @(negedge clk)
		if (rsp_v === 1'b1)
			check(rsp_d, expq.size() != 0 ? expq.pop_front() : 32'h10);
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#300000;
		bad_count++;
		tally_and_finish();
	end
	initial
	begin
		logic [31:0] r;
		rst_n = 1'b0;
		valid = 1'b0;
		cmd = '0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 16; i++)
			send(op_t'(i), 9'h005, 9'(i), 4'h5, 4'ha, 1'b0);
		for (int i = 0; i < 400; i++)
		begin
			r = rnd();
			send(r[31] ? OP_READ : op_t'(r[3:0]), {7'h0, r[5:4]}, {5'h0, r[9:6]},
				r[13:10], r[17:14], r[18]);
		end
		for (int i = 0; i < 64; i++)
			send(OP_READ, 9'(i >> 4), 9'(i & 15), 4'h0, 4'h0, 1'b1);
		valid = 1'b0;
		repeat (40) @(posedge clk);
		check(expq.size(), 0);
		check(faults, 0);
		tally_and_finish();
	end
endmodule
